// file: common/bslw_pkg.sv
// Purpose: shared constants and types for the board status lamp and watchdog block
// Assumes: 100 MHz reference clock, Avalon-MM register access with 32-bit data
// Notes:   times are kept in their own units; cycle counts derive from them
package bslw_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ          = 100000;
	localparam int unsigned WD_BASE_MS       = 125;
	localparam int unsigned WD_STEPS         = 16;
	localparam int unsigned POWER_ON_SELF_TEST_CODE_HOLD_MS     = 500;
	localparam int unsigned BLINK_HALF_MS    = 250;
	localparam int unsigned WD_BASE_CYC_DEF  = WD_BASE_MS * CLK_KHZ;
	localparam int unsigned POWER_ON_SELF_TEST_CODE_HOLD_CYC_DEF = POWER_ON_SELF_TEST_CODE_HOLD_MS * CLK_KHZ;
	localparam int unsigned BLINK_HALF_CYC_DEF = BLINK_HALF_MS * CLK_KHZ;
	localparam int unsigned WD_CNT_W         = 40;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 5;
	localparam logic [4:0] REG_WD_CTRL   = 5'h00;
	localparam logic [4:0] REG_WD_SVC    = 5'h04;
	localparam logic [4:0] REG_STATUS    = 5'h08;
	localparam logic [4:0] REG_LAMP_CFG  = 5'h0C;
	localparam logic [4:0] REG_POWER_ON_SELF_TEST_CODE_CODE = 5'h10;
	localparam logic [4:0] REG_LAMP_APP  = 5'h14;
	localparam logic [4:0] REG_IRQ_STAT  = 5'h18;
	localparam logic [4:0] REG_IRQ_MASK  = 5'h1C;

	// field positions
	localparam int unsigned WD_SEL_LSB   = 0;
	localparam int unsigned WD_MODE_LSB  = 4;
	localparam int unsigned WD_EN_BIT    = 6;
	localparam int unsigned CFG_POWER_ON_SELF_TEST_CODE_BIT = 0;
	localparam int unsigned CFG_BOOT_BIT = 1;
	localparam int unsigned CFG_MIR_LSB  = 4;
	localparam int unsigned APP_RED_LSB  = 4;
	localparam int unsigned IRQ_W        = 3;
	localparam int unsigned IRQ_WD       = 0;
	localparam int unsigned IRQ_SHUT     = 1;
	localparam int unsigned IRQ_THROT    = 2;

	// reset values
	localparam logic [6:0] WD_CTRL_RST   = 7'h00;
	localparam logic [7:0] LAMP_CFG_RST  = 8'h00;
	localparam logic [7:0] LAMP_APP_RST  = 8'h00;
	localparam logic [7:0] POWER_ON_SELF_TEST_CODE_CODE_RST = 8'h00;
	localparam logic [2:0] IRQ_RST       = 3'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {WD_TIMER, WD_RESET, WD_IRQ, WD_DUAL} bslw_wd_mode_e;
	typedef enum {WDS_IDLE, WDS_ARMED, WDS_STAGE2, WDS_EXPIRED} bslw_wd_state_e;
	typedef enum {PH_DARK, PH_HIGH, PH_LOW} bslw_power_on_self_test_code_phase_e;

	typedef struct packed {
		logic red;
		logic green;
	} bslw_lamp_s;

	typedef struct packed {
		logic power_fail;
		logic cpu_cat_err;
		logic hw_reset;
		logic fw_boot_fail;
	} bslw_fail_s;

endpackage : bslw_pkg

// file: hdl/bslw_top.sv
// Purpose: watchdog, thermal lamp and general lamp logic with an Avalon-MM register slave
// Assumes: all inputs synchronous to ref_clk_in; power cycle is seen as rst_b_in
// Notes:   one wait state on every bus access; unmapped reads return zero
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bslw_top
	import bslw_pkg::*;
#(
	parameter int unsigned WD_BASE_CYCLES    = WD_BASE_CYC_DEF,
	parameter int unsigned POWER_ON_SELF_TEST_CODE_HOLD_CYCLES  = POWER_ON_SELF_TEST_CODE_HOLD_CYC_DEF,
	parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC_DEF
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rst_b_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic      [31:0]       avs_readdata_out,
	output logic                   avs_waitrequest_out,
	input  wire bslw_fail_s        fail_flags_in,
	input  wire logic              power_good_in,
	input  wire logic              cpu_throttle_in,
	input  wire logic              cpu_overtemp_in,
	output logic                   irq_out,
	output logic                   wd_reset_out,
	output bslw_lamp_s             watchdog_status_lamp_out,
	output bslw_lamp_s             thermal_status_lamp_out,
	output bslw_lamp_s [3:0]       general_lamps_out
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] wmask;
	logic [31:0] rd_mux;
	logic        wr_fire;
	logic        req;

	logic [6:0]          wd_ctrl_reg;
	logic [7:0]          lamp_cfg_reg;
	logic [7:0]          lamp_app_reg;
	logic [7:0]          power_on_self_test_code_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_mask_reg;
	logic [IRQ_W-1:0]    irq_evt;
	bslw_wd_state_e      wd_state_reg;
	logic [WD_CNT_W-1:0] wd_cnt_reg;
	logic [WD_CNT_W-1:0] wd_limit;
	logic                wd_hit;
	logic                wd_svc;
	logic                wd_rst_reg;
	bslw_wd_mode_e       wd_mode;
	logic                shut_reg;
	logic                shut_d_reg;
	logic                throt_d_reg;
	logic [31:0]         blink_cnt_reg;
	logic                blink_reg;
	bslw_power_on_self_test_code_phase_e    ph_reg;
	logic [31:0]         ph_cnt_reg;
	logic [3:0]          nibble;
	logic [3:0]          fail_vec;
	bslw_lamp_s          wd_lamp_reg;
	bslw_lamp_s          th_lamp_reg;
	bslw_lamp_s [3:0]    gen_lamp_reg;

	assign req                 = avs_read_in | avs_write_in;
	// one wait state gives the read mux a full cycle before data must stand
	assign avs_waitrequest_out = req & ~ack_reg;
	assign wr_fire             = avs_write_in & ack_reg;
	assign avs_readdata_out    = rdata_reg;
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
	                {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_in)
			REG_WD_CTRL:   rd_mux[6:0] = wd_ctrl_reg;
			REG_STATUS:    rd_mux[7:0] = {2'(ph_reg), cpu_throttle_in, shut_reg,
			                              wd_state_reg == WDS_STAGE2, wd_state_reg == WDS_EXPIRED,
			                              wd_state_reg == WDS_ARMED, wd_state_reg == WDS_IDLE};
			REG_LAMP_CFG:  rd_mux[7:0] = lamp_cfg_reg;
			REG_POWER_ON_SELF_TEST_CODE_CODE: rd_mux[7:0] = power_on_self_test_code_reg;
			REG_LAMP_APP:  rd_mux[7:0] = lamp_app_reg;
			REG_IRQ_STAT:  rd_mux[IRQ_W-1:0] = irq_stat_reg;
			REG_IRQ_MASK:  rd_mux[IRQ_W-1:0] = irq_mask_reg;
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (avs_read_in && !ack_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_ctrl_reg                 <= WD_CTRL_RST;
			lamp_cfg_reg                <= LAMP_CFG_RST;
			lamp_app_reg                <= LAMP_APP_RST;
			power_on_self_test_code_reg <= POWER_ON_SELF_TEST_CODE_CODE_RST;
			irq_mask_reg                <= IRQ_RST;
		end else if (wr_fire) begin
			case (avs_address_in)
				REG_WD_CTRL:   wd_ctrl_reg <= (wd_ctrl_reg & ~wmask[6:0]) | (avs_writedata_in[6:0] & wmask[6:0]);
				REG_LAMP_CFG:  lamp_cfg_reg <= (lamp_cfg_reg & ~wmask[7:0]) | (avs_writedata_in[7:0] & wmask[7:0]);
				REG_LAMP_APP:  lamp_app_reg <= (lamp_app_reg & ~wmask[7:0]) | (avs_writedata_in[7:0] & wmask[7:0]);
				REG_POWER_ON_SELF_TEST_CODE_CODE: power_on_self_test_code_reg <= (power_on_self_test_code_reg & ~wmask[7:0])
				                                              | (avs_writedata_in[7:0] & wmask[7:0]);
				REG_IRQ_MASK:  irq_mask_reg <= (irq_mask_reg & ~wmask[IRQ_W-1:0])
				                               | (avs_writedata_in[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
				default:       ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	// a new event in the clearing cycle survives: set wins over clear
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_stat_reg <= IRQ_RST;
		end else if (wr_fire && avs_address_in == REG_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~(avs_writedata_in[IRQ_W-1:0] & wmask[IRQ_W-1:0])) | irq_evt;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_evt;
		end
	end

	assign irq_out = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	assign wd_mode  = bslw_wd_mode_e'(wd_ctrl_reg[WD_MODE_LSB +: 2]);
	assign wd_limit = WD_CNT_W'(WD_BASE_CYCLES) << wd_ctrl_reg[WD_SEL_LSB +: 4];
	assign wd_hit   = (wd_cnt_reg == wd_limit - WD_CNT_W'(1));
	assign wd_svc   = wr_fire && avs_address_in == REG_WD_SVC;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_state_reg <= WDS_IDLE;
			wd_cnt_reg   <= '0;
		end else if (!wd_ctrl_reg[WD_EN_BIT]) begin
			wd_state_reg <= WDS_IDLE;
			wd_cnt_reg   <= '0;
		end else begin
			case (wd_state_reg)
				WDS_IDLE: begin
					wd_state_reg <= WDS_ARMED;
					wd_cnt_reg   <= '0;
				end
				WDS_ARMED, WDS_STAGE2: begin
					if (wd_svc) begin
						wd_state_reg <= WDS_ARMED;
						wd_cnt_reg   <= '0;
					end else if (wd_hit) begin
						wd_cnt_reg <= '0;
						if (wd_state_reg == WDS_ARMED && wd_mode == WD_DUAL) begin
							wd_state_reg <= WDS_STAGE2;
						end else begin
							wd_state_reg <= WDS_EXPIRED;
						end
					end else begin
						wd_cnt_reg <= wd_cnt_reg + WD_CNT_W'(1);
					end
				end
				WDS_EXPIRED: begin
					if (wd_svc) begin
						wd_state_reg <= WDS_ARMED;
						wd_cnt_reg   <= '0;
					end
				end
				default: wd_state_reg <= WDS_IDLE;
			endcase
		end
	end

	// the reset request is a single pulse; the system reset generator stretches it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_rst_reg <= 1'b0;
		end else begin
			wd_rst_reg <= wd_ctrl_reg[WD_EN_BIT] && !wd_svc && wd_hit
			              && ((wd_state_reg == WDS_ARMED && wd_mode == WD_RESET)
			              || wd_state_reg == WDS_STAGE2);
		end
	end

	assign wd_reset_out = wd_rst_reg;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_lamp_reg <= '0;
		end else begin
			wd_lamp_reg.green <= wd_state_reg == WDS_ARMED || wd_state_reg == WDS_STAGE2;
			wd_lamp_reg.red   <= wd_state_reg == WDS_EXPIRED;
		end
	end

	assign watchdog_status_lamp_out = wd_lamp_reg;

	// ----------------------------------------------------------------
	// thermal
	// ----------------------------------------------------------------
	// only a power cycle (rst_b_in) releases the shutdown latch
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shut_reg    <= 1'b0;
			shut_d_reg  <= 1'b0;
			throt_d_reg <= 1'b0;
		end else begin
			shut_reg    <= shut_reg | cpu_overtemp_in;
			shut_d_reg  <= shut_reg;
			throt_d_reg <= cpu_throttle_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b0;
		end else if (blink_cnt_reg == BLINK_HALF_CYCLES - 1) begin
			blink_cnt_reg <= '0;
			blink_reg     <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
		end
	end

	assign irq_evt[IRQ_WD]    = wd_ctrl_reg[WD_EN_BIT] && !wd_svc && wd_hit && wd_state_reg == WDS_ARMED
	                            && (wd_mode == WD_IRQ || wd_mode == WD_DUAL);
	assign irq_evt[IRQ_SHUT]  = shut_reg & ~shut_d_reg;
	assign irq_evt[IRQ_THROT] = cpu_throttle_in & ~throt_d_reg;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			th_lamp_reg <= '0;
		end else if (!power_good_in) begin
			th_lamp_reg <= '0;
		end else if (shut_reg) begin
			th_lamp_reg <= '{red: blink_reg, green: 1'b0};
		end else if (cpu_throttle_in) begin
			th_lamp_reg <= '{red: 1'b1, green: 1'b0};
		end else begin
			th_lamp_reg <= '{red: 1'b0, green: 1'b1};
		end
	end

	assign thermal_status_lamp_out = th_lamp_reg;

	// ----------------------------------------------------------------
	// self-test code multiplexer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ph_reg     <= PH_DARK;
			ph_cnt_reg <= '0;
		end else if (ph_cnt_reg == POWER_ON_SELF_TEST_CODE_HOLD_CYCLES - 1) begin
			ph_cnt_reg <= '0;
			case (ph_reg)
				PH_DARK: ph_reg <= PH_HIGH;
				PH_HIGH: ph_reg <= PH_LOW;
				PH_LOW:  ph_reg <= PH_DARK;
				default: ph_reg <= PH_DARK;
			endcase
		end else begin
			ph_cnt_reg <= ph_cnt_reg + 32'h0000_0001;
		end
	end

	always_comb begin
		case (ph_reg)
			PH_HIGH: nibble = power_on_self_test_code_reg[7:4];
			PH_LOW:  nibble = power_on_self_test_code_reg[3:0];
			default: nibble = 4'h0;
		endcase
	end

	assign fail_vec = fail_flags_in;

	// ----------------------------------------------------------------
	// general lamps
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : gen_lamp
		always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				gen_lamp_reg[g] <= '0;
			end else if (shut_reg) begin
				gen_lamp_reg[g] <= '{red: blink_reg, green: 1'b0};
			end else if (!lamp_cfg_reg[CFG_BOOT_BIT]) begin
				gen_lamp_reg[g].red   <= fail_vec[g];
				gen_lamp_reg[g].green <= lamp_cfg_reg[CFG_POWER_ON_SELF_TEST_CODE_BIT] & nibble[g];
			end else if (lamp_cfg_reg[CFG_MIR_LSB + g]) begin
				gen_lamp_reg[g] <= '{red: 1'b0, green: nibble[g]};
			end else begin
				gen_lamp_reg[g].red   <= lamp_app_reg[APP_RED_LSB + g];
				gen_lamp_reg[g].green <= lamp_app_reg[g];
			end
		end
	end

	assign general_lamps_out = gen_lamp_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	wd_expire_step_a: assert property (wd_state_reg == WDS_ARMED && wd_hit && !wd_svc && wd_ctrl_reg[WD_EN_BIT]
		&& wd_mode != WD_DUAL |=> wd_state_reg == WDS_EXPIRED) else $error("watchdog missed expiry");
	wd_reset_mode_a: assert property (wd_state_reg == WDS_ARMED && wd_hit && !wd_svc && wd_ctrl_reg[WD_EN_BIT]
		&& wd_mode == WD_RESET |=> wd_reset_out) else $error("reset mode gave no reset");
	dual_stage_a: assert property (wd_state_reg == WDS_ARMED && wd_hit && !wd_svc && wd_ctrl_reg[WD_EN_BIT]
		&& wd_mode == WD_DUAL |=> irq_stat_reg[IRQ_WD] && wd_state_reg == WDS_STAGE2)
		else $error("dual stage first expiry wrong");
	wd_lamp_map_a: assert property (wd_state_reg == WDS_EXPIRED |=> watchdog_status_lamp_out.red
		&& !watchdog_status_lamp_out.green) else $error("watchdog lamp not red");
	th_normal_a: assert property (power_good_in && !shut_reg && !cpu_throttle_in |=> thermal_status_lamp_out.green)
		else $error("thermal lamp not green");
	th_throttle_a: assert property (power_good_in && !shut_reg && cpu_throttle_in |=> thermal_status_lamp_out.red)
		else $error("thermal lamp not red on throttle");
	th_blink_a: assert property (power_good_in && shut_reg |=> thermal_status_lamp_out.red == $past(blink_reg))
		else $error("thermal lamp not blinking");
	gen_blink_a: assert property (shut_reg |=> general_lamps_out[3].red == thermal_status_lamp_out.red
		|| !$past(power_good_in)) else $error("general lamps not blinking");
	th_latch_a: assert property ($rose(shut_reg) |=> shut_reg [*8]) else $error("shutdown latch dropped");
	fail_red_a: assert property (!shut_reg && !lamp_cfg_reg[CFG_BOOT_BIT] |=> general_lamps_out[3].red
		== $past(fail_flags_in.power_fail)) else $error("power fail flag not shown");
	power_on_self_test_code_dark_a: assert property (!shut_reg && ph_reg == PH_DARK |=> general_lamps_out[0].green == 1'b0
		|| ($past(lamp_cfg_reg[CFG_BOOT_BIT]) && !$past(lamp_cfg_reg[CFG_MIR_LSB])))
		else $error("dark phase lit");
	power_on_self_test_code_gate_a: assert property (!shut_reg && !lamp_cfg_reg[CFG_BOOT_BIT] && !lamp_cfg_reg[CFG_POWER_ON_SELF_TEST_CODE_BIT]
		&& $stable(lamp_cfg_reg) |=> general_lamps_out[2].green == 1'b0) else $error("code shown while off");

endmodule : bslw_top

`default_nettype wire

// file: tb/test_board_status_led_and_watchdog.sv
// Purpose: self-checking bench for the status lamp and watchdog block
// Assumes: shortened counts via top parameters; one wait state per bus access
// Notes:   drivers queue expected values; a monitor compares them as results appear
`timescale 1ns/1ps
`default_nettype none
module test_board_status_led_and_watchdog;
	import bslw_pkg::*;
	localparam int WB = 20, PH = 4, BH = 3;
	typedef struct {int sel; logic [31:0] exp; logic [31:0] msk; string nm;} bslw_note_s;
	logic             clk, rst_b, rd, wr, probe, wait_r, irq, wdr, pg, thr, ovt;
	logic [4:0]       adr;
	logic [31:0]      wdat, rdat, obs;
	logic [3:0]       be, gn, mir;
	logic [7:0]       code, app;
	bslw_fail_s       ff;
	bslw_lamp_s       wdl, thl;
	bslw_lamp_s [3:0] gl;
	bslw_note_s       q[$], cur;
	int               err_count, samples_checked, pulses, meas, seed;
	assign obs = {18'h0, irq, wdr, wdl, thl, gl};
	assign gn  = {gl[3].green, gl[2].green, gl[1].green, gl[0].green};
	bslw_top #(.WD_BASE_CYCLES(WB), .POWER_ON_SELF_TEST_CODE_HOLD_CYCLES(PH), .BLINK_HALF_CYCLES(BH)) u_dut (
		.ref_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .fail_flags_in(ff),
		.power_good_in(pg), .cpu_throttle_in(thr), .cpu_overtemp_in(ovt), .irq_out(irq),
		.wd_reset_out(wdr), .watchdog_status_lamp_out(wdl), .thermal_status_lamp_out(thl),
		.general_lamps_out(gl)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results;
		$display("checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	task automatic tmo;
		err_count++;
		$display("MISMATCH wait expected done seen timeout");
		results();
	endtask : tmo
	// results land in a fixed order, so the oldest note always belongs to the next result
	always @(posedge clk) begin
		if (wdr === 1'b1) pulses++;
		if ((rd && wait_r === 1'b0) || probe) begin
			if (q.size() == 0) check("queue", 32'h1, 32'h0);
			else begin
				cur = q.pop_front();
				check(cur.nm, (cur.sel == 0 ? rdat : cur.sel == 1 ? obs : 32'(meas)) & cur.msk, cur.exp & cur.msk);
			end
		end
	end
	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic note(input int sel, input logic [31:0] exp, input logic [31:0] msk, input string nm);
		bslw_note_s n;
		n = '{sel, exp, msk, nm};
		q.push_back(n);
	endtask : note
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int t;
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (wait_r !== 1'b0 && t < 50);
		if (t >= 50) tmo();
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rdx(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		note(0, e, m, nm);
		bus(1'b0, a, 32'h0);
	endtask : rdx
	task automatic pr(input int sel, input logic [31:0] e, input logic [31:0] m, input string nm);
		note(sel, e, m, nm);
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
		@(posedge clk);
	endtask : pr
	task automatic wait_gn(input logic [3:0] v);
		int t;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (gn !== v && t < 60);
		if (t >= 60) tmo();
	endtask : wait_gn
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [4:0] ra [7];
		int k, lim, p0, t, cnt, acc;
		logic [3:0] v1, v2;
		logic [31:0] m2, e2;
		ra = '{REG_WD_CTRL, REG_LAMP_CFG, REG_POWER_ON_SELF_TEST_CODE_CODE, REG_LAMP_APP, REG_IRQ_STAT, REG_IRQ_MASK, 5'h03};
		{rst_b, rd, wr, probe, thr, ovt, adr, wdat} = '0;
		{pg, be, ff} = {1'b1, 4'hF, 4'h0};
		{err_count, samples_checked, pulses, meas} = '0;
		seed = $urandom(33);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		foreach (ra[i]) rdx(ra[i], 32'h0, 32'hFF, "reset value");
		rdx(REG_STATUS, 32'h1, 32'h3F, "status idle");
		pr(1, 32'h100, 32'h3FFF, "lamps after reset");
		$display("test reset done");
		bus(1'b1, REG_IRQ_MASK, 32'h7);
		for (int m = 0; m < 4; m++) begin
			k = $urandom_range(2);
			lim = WB << k;
			p0 = pulses;
			bus(1'b1, REG_WD_CTRL, 32'h40 | (m << 4) | k);
			repeat (lim - 10) @(posedge clk);
			rdx(REG_STATUS, 32'h2, 32'hF, "armed before limit");
			pr(1, 32'h400, 32'hC00, "watchdog lamp green");
			repeat (12) @(posedge clk);
			rdx(REG_STATUS, m == 3 ? 32'h8 : 32'h4, 32'hF, "state at limit");
			rdx(REG_IRQ_STAT, 32'(m >= 2), 32'h1, "watchdog irq");
			pr(1, {18'h0, m >= 2, 1'b0, m == 3 ? 2'b01 : 2'b10, 10'h0}, 32'h2C00, "irq and lamp");
			if (m == 3) begin
				repeat (lim) @(posedge clk);
				rdx(REG_STATUS, 32'h4, 32'hF, "second stage expiry");
			end
			meas = pulses - p0;
			pr(2, 32'(m == 1 || m == 3), 32'hFF, "reset pulses");
			bus(1'b1, REG_IRQ_STAT, 32'h1);
			bus(1'b1, REG_WD_CTRL, 32'h0);
			rdx(REG_IRQ_STAT, 32'h0, 32'h1, "irq cleared");
			pr(1, 32'h0, 32'h2C00, "off when disabled");
		end
		bus(1'b1, REG_WD_CTRL, 32'h40);
		repeat (4) begin
			repeat (8) @(posedge clk);
			bus(1'b1, REG_WD_SVC, $urandom);
		end
		rdx(REG_STATUS, 32'h2, 32'hF, "serviced stays armed");
		bus(1'b1, REG_WD_CTRL, 32'h0);
		$display("test watchdog done");
		ff <= 4'($urandom);
		code = {4'h8 | 4'($urandom), 4'h1 | 4'($urandom_range(6))};
		bus(1'b1, REG_POWER_ON_SELF_TEST_CODE_CODE, {24'h0, code});
		bus(1'b1, REG_LAMP_CFG, 32'h1);
		wait_gn(code[7:4]);
		t = 0;
		while (gn === code[7:4] && t < 60) begin
			@(negedge clk);
			t++;
		end
		v1 = gn;
		cnt = 0;
		while (gn === v1 && cnt < 60) begin
			@(negedge clk);
			cnt++;
		end
		v2 = gn;
		if (t >= 60 || cnt >= 60) tmo();
		@(posedge clk);
		meas = v1;
		pr(2, code[3:0], 32'hF, "nibble after high");
		meas = cnt;
		pr(2, PH, 32'hFF, "phase hold");
		meas = v2;
		pr(2, 32'h0, 32'hF, "dark after low");
		pr(1, {ff[3], 1'b0, ff[2], 1'b0, ff[1], 1'b0, ff[0], 1'b0}, 32'hAA, "boot fail flags");
		bus(1'b1, REG_LAMP_CFG, 32'h0);
		acc = 0;
		repeat (14) begin
			@(negedge clk);
			acc |= gn;
		end
		@(posedge clk);
		meas = acc;
		pr(2, 32'h0, 32'hF, "display disabled");
		$display("test boot display done");
		app = 8'($urandom);
		mir = 4'($urandom) | 4'h1;
		bus(1'b1, REG_LAMP_APP, {24'h0, app});
		bus(1'b1, REG_LAMP_CFG, {24'h0, mir, 4'h3});
		{m2, e2} = '0;
		for (int n = 0; n < 4; n++) begin
			if (!mir[n]) m2 |= 32'h3 << (2 * n);
			e2 |= {app[n + 4], app[n]} << (2 * n);
		end
		pr(1, e2, m2, "application lamps");
		acc = 0;
		repeat (14) begin
			@(negedge clk);
			acc |= gn & mir;
		end
		@(posedge clk);
		meas = acc;
		pr(2, (code[7:4] | code[3:0]) & mir, 32'hF, "mirrored nibbles");
		$display("test after boot done");
		pg <= 1'b0;
		// the lamp is registered: let one edge take the new input before probing
		@(posedge clk);
		pr(1, 32'h0, 32'h300, "power fail off");
		pg <= 1'b1;
		thr <= 1'b1;
		@(posedge clk);
		pr(1, 32'h200, 32'h300, "throttle red");
		bus(1'b1, REG_IRQ_MASK, 32'h0);
		pr(1, 32'h0, 32'h2000, "event masked");
		bus(1'b1, REG_IRQ_MASK, 32'h4);
		pr(1, 32'h2000, 32'h2000, "event unmasked");
		bus(1'b1, REG_IRQ_STAT, 32'h4);
		pr(1, 32'h0, 32'h2000, "event cleared");
		ovt <= 1'b1;
		repeat (2) @(posedge clk);
		ovt <= 1'b0;
		thr <= 1'b0;
		repeat (2) @(posedge clk);
		{cnt, acc} = '0;
		repeat (4 * BH) begin
			@(negedge clk);
			cnt += thl.red;
			if (gl !== {4{thl.red, 1'b0}} || thl.green !== 1'b0) acc++;
		end
		@(posedge clk);
		meas = cnt;
		pr(2, 2 * BH, 32'hFF, "blink red cycles");
		meas = acc;
		pr(2, 32'h0, 32'hFF, "lamps blink together");
		rdx(REG_IRQ_STAT, 32'h2, 32'h2, "shutdown event");
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		pr(1, 32'h100, 32'h355, "normal after power cycle");
		$display("test thermal done");
		check("pending notes", 32'(q.size()), 32'h0);
		results();
	end
endmodule : test_board_status_led_and_watchdog
`default_nettype wire
